//--- iocg_pkg.sv
// shared constants, types and helpers of the io cell gearing path
package iocg_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [7:0]  A_CTRL      = 8'h00;
   localparam logic [7:0]  A_CMD       = 8'h04;
   localparam logic [7:0]  A_STAT      = 8'h08;
   localparam logic [7:0]  A_EDGE      = 8'h0C;
   localparam int          CMD_SLIP    = 0;
   localparam int          CMD_ECLR    = 1;
   localparam int          STAT_OVF    = 0;
   localparam int          STAT_LVL    = 1;
   localparam int          STAT_EYE    = 7;
   localparam logic [13:0] CTRL_RST    = 14'h0008;

   // ------------------------------------------------------------
   // gearing constants
   // ------------------------------------------------------------
   localparam logic [2:0]  R2          = 3'h0;
   localparam logic [2:0]  R4          = 3'h1;
   localparam logic [2:0]  R8          = 3'h2;
   localparam logic [2:0]  R10         = 3'h3;
   localparam logic [2:0]  R7          = 3'h4;
   localparam int          WORD_W      = 10;
   localparam int          FIFO_D      = 32;
   localparam int          LVL_W       = 6;
   localparam int          BUF_W       = 16;
   localparam int          TXB_W       = 32;
   localparam int          DLY_N       = 8;
   localparam logic [4:0]  HALF_BITS   = 5'h02;
   localparam logic [4:0]  SH_CNT_MAX  = 5'h0B;
   localparam logic [5:0]  TX_FILL_MAX = 6'h16;
   localparam logic [5:0]  TX_CAP      = 6'h20;
   localparam logic [15:0] EDGE_MAX    = 16'hFFFF;

   typedef struct packed {
      logic [2:0] tx_dly;
      logic [2:0] rx_dly;
      logic       filt_byp;
      logic       tx_inv;
      logic       rx_inv;
      logic       diff_en;
      logic       bank_hp;
      logic [2:0] ratio;
   } iocg_ctrl_s;

   typedef struct packed {
      logic fall;
      logic rise;
   } iocg_pair_s;

   // bits per core word; the wide range bank gears 2:1 only
   function automatic logic [4:0] iocg_ratio_bits(logic [2:0] r, logic hp);
      logic [4:0] n;
      n = 5'h02;
      if (hp) begin
         case (r)
            R4:      n = 5'h04;
            R8:      n = 5'h08;
            R10:     n = 5'h0A;
            R7:      n = 5'h07;
            default: n = 5'h02;
         endcase
      end
      return n;
   endfunction

endpackage

//--- iocg_gear.sv
// io cell gearing path: rx deserializer, fifo, tx serializer, regs
//
// Our own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------
// fifo with valid/ready on both sides
// ------------------------------------------------------------
module iocg_fifo #(
   parameter int W = 10,
   parameter int D = 32,
   parameter int A = $clog2(D)
) (
   input  wire logic         hclk,
   input  wire logic         hresetn,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [A:0]        level
);
   logic [W-1:0] mem [D];
   logic [A:0]   wp_q;
   logic [A:0]   rp_q;

   assign level     = wp_q - rp_q;
   assign in_ready  = (level != D[A:0]);
   assign out_valid = (wp_q != rp_q);
   assign out_data  = mem[rp_q[A-1:0]];

   always_ff @(posedge hclk) begin
      if (in_valid && in_ready) begin
         mem[wp_q[A-1:0]] <= in_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wp_q <= wp_q + 1'b1;
         end
         if (out_valid && out_ready) begin
            rp_q <= rp_q + 1'b1;
         end
      end
   end
endmodule

// How it works
// RULE_01 - rx gears 2:1, 4:1, 8:1 or 10:1 from pad pairs to core words; the code gears rx 2:1 only when bank_hp is clear
// RULE_02 - rx also offers a 7:1 mode for seven-bit video links; the code offers it only when bank_hp is set
// RULE_03 - rx uses shift, update and transfer register stages
// RULE_04 - first stage captures pad data of both edge clock phases
// RULE_05 - update stage aligns bits into words; slip command moves alignment
// RULE_06 - transfer stage registers the aligned word towards the core
// RULE_07 - high performance rx word path runs through a built-in fifo
// RULE_08 - rx has a selectable delay ahead of the capture logic
// RULE_09 - core tx data and enables are registered before the pad
// RULE_10 - tx gears 2:1, 4:1, 8:1, 10:1 or 7:1 in high performance mode
// RULE_11 - wide range bank transmits with 2:1 gearing only
// RULE_12 - tx data has a programmable delay line
// RULE_13 - tristate control is registered once and drives the pad enable
// RULE_14 - separate input, output and tristate register blocks
// RULE_15 - edge monitor counts edges per phase to find the eye centre
// RULE_16 - rx and tx polarity can each be inverted; the code inverts only when bank_hp is set
// RULE_17 - wide range inputs pass a glitch filter that can be bypassed
// RULE_18 - two slices pair as true and complement of one channel
// RULE_19 - N core bits per accepted word leave on successive half periods
module iocg_gear
   import iocg_pkg::*;
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata_q,
   output logic                   hreadyout_q,
   output logic                   hresp_q,
   input  wire iocg_pair_s        pad_in_first,
   output iocg_pair_s             pad_out_first_q,
   output logic                   pad_oe_first_q,
   output iocg_pair_s             pad_out_second_q,
   output logic                   pad_oe_second_q,
   input  wire logic              tristate_ctrl_in,
   output logic [WORD_W-1:0]      rx_word_q,
   output logic                   rx_valid_q,
   input  wire logic              rx_ready,
   input  wire logic [WORD_W-1:0] tx_word,
   input  wire logic              tx_valid,
   output logic                   tx_ready_q
);
   iocg_ctrl_s        ctrl_q;
   logic              wr_q;
   logic [7:0]        wa_q;
   logic              rd_q;
   logic [7:0]        ra_q;
   logic              slip_q;
   logic              eclr_q;
   logic              ovf_q;
   logic [15:0]       er_q;
   logic [15:0]       ef_q;
   logic [4:0]        rx_n;
   logic [4:0]        tx_n;
   iocg_pair_s        dly_q [DLY_N];
   iocg_pair_s        tdly_q [DLY_N];
   iocg_pair_s        raw;
   iocg_pair_s        flt;
   iocg_pair_s        hist_q;
   logic [BUF_W-1:0]  sh_q;
   logic [BUF_W-1:0]  sh_d;
   logic [4:0]        shc_q;
   logic [4:0]        shc_d;
   logic              take;
   logic [WORD_W-1:0] upd_d;
   logic [WORD_W-1:0] upd_q;
   logic              upd_v_q;
   logic [WORD_W-1:0] xfr_q;
   logic              xfr_v_q;
   logic              f_in_ready;
   logic [WORD_W-1:0] f_out;
   logic              f_out_v;
   logic              pop;
   logic [LVL_W-1:0]  f_lvl;
   logic [TXB_W-1:0]  tb_q;
   logic [TXB_W-1:0]  tb_d;
   logic [5:0]        tc_q;
   logic [5:0]        tc_d;
   logic              acc;
   iocg_pair_s        tx_pair;
   logic [31:0]       rdata;

   assign rx_n = iocg_ratio_bits(ctrl_q.ratio, ctrl_q.bank_hp);      // RULE_01
   assign tx_n = iocg_ratio_bits(ctrl_q.ratio, ctrl_q.bank_hp);      // RULE_11

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q        <= 1'b0;
         wa_q        <= '0;
         rd_q        <= 1'b0;
         ra_q        <= '0;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         hrdata_q    <= '0;
      end else begin
         wr_q <= hsel && htrans[1] && hready && hwrite;
         rd_q <= hsel && htrans[1] && hready && !hwrite;
         if (hsel && htrans[1] && hready) begin
            wa_q <= haddr[7:0];
            ra_q <= haddr[7:0];
         end
         // reads take one wait state so a prior write is seen
         hreadyout_q <= !(hsel && htrans[1] && hready && !hwrite);
         hresp_q     <= 1'b0;
         if (rd_q) begin
            hrdata_q <= rdata;
         end
      end
   end

   always_comb begin
      rdata = '0;
      case (ra_q)
         A_CTRL:  rdata = {18'h00000, ctrl_q};
         A_STAT:  rdata = {24'h000000, (er_q > ef_q), f_lvl, ovf_q};
         A_EDGE:  rdata = {ef_q, er_q};
         default: rdata = '0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= CTRL_RST;
      end else if (wr_q && wa_q == A_CTRL) begin
         ctrl_q <= hwdata[13:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slip_q <= 1'b0;
         eclr_q <= 1'b0;
      end else begin
         slip_q <= wr_q && wa_q == A_CMD && hwdata[CMD_SLIP];
         eclr_q <= wr_q && wa_q == A_CMD && hwdata[CMD_ECLR];
      end
   end

   // ------------------------------------------------------------
   // input register block
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < DLY_N; i++) begin
            dly_q[i] <= '0;
         end
         hist_q <= '0;
      end else begin
         dly_q[0] <= pad_in_first;                                   // RULE_04
         for (int i = 1; i < DLY_N; i++) begin
            dly_q[i] <= dly_q[i-1];                                  // RULE_08
         end
         hist_q <= raw;
      end
   end

   always_comb begin
      raw = dly_q[ctrl_q.rx_dly];                                    // RULE_08
      flt = raw;
      if (!ctrl_q.bank_hp && !ctrl_q.filt_byp) begin                 // RULE_17
         flt.rise = (hist_q.rise & hist_q.fall) | (hist_q.rise & raw.rise)
                  | (hist_q.fall & raw.rise);
         flt.fall = (hist_q.fall & raw.rise) | (hist_q.fall & raw.fall)
                  | (raw.rise & raw.fall);
      end
      if (ctrl_q.bank_hp && ctrl_q.rx_inv) begin
         flt = ~flt;                                                 // RULE_16
      end
   end

   // shift stage: append two half-period bits, emit N when present
   always_comb begin
      take  = (shc_q >= rx_n);                                       // RULE_02
      upd_d = '0;
      sh_d  = sh_q;
      shc_d = shc_q;
      if (take) begin
         upd_d = WORD_W'(sh_q & ((BUF_W'(1) << rx_n) - BUF_W'(1)));  // RULE_05
         sh_d  = sh_q >> rx_n;
         shc_d = shc_q - rx_n;
      end
      sh_d  = sh_d | (BUF_W'({flt.fall, flt.rise}) << shc_d);        // RULE_03
      shc_d = shc_d + HALF_BITS;
      // slip drops the oldest bit after the append, so it acts every mode
      if (slip_q) begin
         sh_d  = sh_d >> 1;                                          // RULE_05
         shc_d = shc_d - 5'h01;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sh_q    <= '0;
         shc_q   <= '0;
         upd_q   <= '0;
         upd_v_q <= 1'b0;
      end else begin
         sh_q    <= sh_d;                                            // RULE_03
         shc_q   <= shc_d;
         upd_q   <= upd_d;                                           // RULE_05
         upd_v_q <= take;
      end
   end

   // transfer stage holds a valid word while the fifo is full
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xfr_q   <= '0;
         xfr_v_q <= 1'b0;
      end else if (!xfr_v_q || f_in_ready) begin
         xfr_q   <= upd_q;                                           // RULE_06
         xfr_v_q <= upd_v_q;
      end
   end

   // lost word is flagged; a new loss wins over a clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_q <= 1'b0;
      end else if (upd_v_q && xfr_v_q && !f_in_ready) begin
         ovf_q <= 1'b1;                                              // RULE_07
      end else if (wr_q && wa_q == A_STAT && hwdata[STAT_OVF]) begin
         ovf_q <= 1'b0;
      end
   end

   iocg_fifo #(.W(WORD_W), .D(FIFO_D)) u_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_data   (xfr_q),
      .in_valid  (xfr_v_q),
      .in_ready  (f_in_ready),
      .out_data  (f_out),
      .out_valid (f_out_v),
      .out_ready (pop),
      .level     (f_lvl)
   );

   assign pop = f_out_v && (!rx_valid_q || rx_ready);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_word_q  <= '0;
         rx_valid_q <= 1'b0;
      end else if (!rx_valid_q || rx_ready) begin
         rx_word_q  <= f_out;                                        // RULE_06
         rx_valid_q <= f_out_v;
      end
   end

   // edge monitor: edges at rising vs falling sample phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         er_q <= '0;
         ef_q <= '0;
      end else if (eclr_q) begin
         er_q <= '0;
         ef_q <= '0;
      end else begin
         if (raw.rise != hist_q.fall && er_q != EDGE_MAX) begin
            er_q <= er_q + 16'h0001;                                 // RULE_15
         end
         if (raw.fall != raw.rise && ef_q != EDGE_MAX) begin
            ef_q <= ef_q + 16'h0001;                                 // RULE_15
         end
      end
   end

   // ------------------------------------------------------------
   // output register block
   // ------------------------------------------------------------
   assign acc = tx_valid && tx_ready_q;

   always_comb begin
      tb_d    = tb_q;
      tc_d    = tc_q;
      tx_pair = '0;
      if (tc_q >= 6'(HALF_BITS)) begin
         tx_pair = {tb_q[1], tb_q[0]};                               // RULE_19
         tb_d    = tb_q >> HALF_BITS;
         tc_d    = tc_q - 6'(HALF_BITS);
      end
      if (acc) begin
         tb_d = tb_d | (TXB_W'(tx_word & WORD_W'((11'h001 << tx_n)
                - 11'h001)) << tc_d);                                // RULE_10
         tc_d = tc_d + 6'(tx_n);
      end
      if (ctrl_q.bank_hp && ctrl_q.tx_inv) begin
         tx_pair = ~tx_pair;                                         // RULE_16
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tb_q       <= '0;
         tc_q       <= '0;
         tx_ready_q <= 1'b0;
      end else begin
         tb_q       <= tb_d;                                         // RULE_09
         tc_q       <= tc_d;
         tx_ready_q <= (tc_d <= TX_FILL_MAX);                        // RULE_19
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < DLY_N; i++) begin
            tdly_q[i] <= '0;
         end
         pad_out_first_q  <= '0;
         pad_out_second_q <= '1;
      end else begin
         tdly_q[0] <= tx_pair;
         for (int i = 1; i < DLY_N; i++) begin
            tdly_q[i] <= tdly_q[i-1];                                // RULE_12
         end
         pad_out_first_q  <= tdly_q[ctrl_q.tx_dly];                  // RULE_12
         pad_out_second_q <= ~tdly_q[ctrl_q.tx_dly];                 // RULE_18
      end
   end

   // ------------------------------------------------------------
   // tristate register block
   // ------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pad_oe_first_q  <= 1'b0;
         pad_oe_second_q <= 1'b0;
      end else begin
         pad_oe_first_q  <= !tristate_ctrl_in;                       // RULE_13
         pad_oe_second_q <= !tristate_ctrl_in && ctrl_q.diff_en;     // RULE_18
      end
   end                                                               // RULE_14

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   shift_bound_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_03
      shc_q <= SH_CNT_MAX) else $error("shift count too large");
   update_cause_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_05
      upd_v_q |-> $past(shc_q) >= $past(rx_n))
      else $error("word emitted without enough bits");
   transfer_move_a: assert property (@(posedge hclk) // RULE_06
      disable iff (!hresetn)
      upd_v_q && !xfr_v_q |=> xfr_v_q && xfr_q == $past(upd_q))
      else $error("transfer stage missed word");
   overflow_set_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_07
      upd_v_q && xfr_v_q && !f_in_ready |=> ovf_q)
      else $error("lost word not flagged");
   tx_drain_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_19
      tc_q >= 6'h02 && !acc |=> tc_q == $past(tc_q) - 6'h02)
      else $error("tx bits not drained two per cycle");
   tx_cap_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_10
      tc_q <= TX_CAP) else $error("tx buffer overrun");
   oe_reg_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_13
      ##1 pad_oe_first_q == !$past(tristate_ctrl_in))
      else $error("pad enable not registered tristate");
   wide_gear_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_11
      !ctrl_q.bank_hp |-> tx_n == 5'h02 && rx_n == 5'h02)
      else $error("wide range bank not 2:1");
   pair_comp_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
      pad_out_second_q == ~pad_out_first_q)
      else $error("complement slice mismatch");
   read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !hreadyout_q |=> hreadyout_q) else $error("read wait too long");
endmodule

`default_nettype wire

//--- iocg_far_end.sv
// far side source-synchronous sender driving a counting pattern on the pads
`timescale 1ns/1ns
`default_nettype none

module iocg_far_end
   import iocg_pkg::*;
(
   input  wire logic     hclk,
   input  wire logic     hresetn,
   input  wire logic     run,
   output var iocg_pair_s pad_q
);
   // ------------------------------------------------------------
   // pattern source
   // ------------------------------------------------------------
   logic [1:0] cnt_q;

   // each pair is the count: rise carries bit0, fall carries bit1
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= 2'h0;
         pad_q <= '0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         pad_q <= run ? iocg_pair_s'(cnt_q) : '0;
      end
   end
endmodule
`default_nettype wire

//--- tb_top.sv
// self-checking testbench of the io cell gearing path
`timescale 1ns/1ns
`default_nettype none

module tb_top
   import iocg_pkg::*;
;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic              hclk, hresetn, hsel, hwrite, hreadyout_q, hresp_q;
   logic [31:0]       haddr, hwdata, hrdata_q, d;
   logic [1:0]        htrans;
   logic              tristate_ctrl_in, rx_ready, tx_valid, run;
   logic              pad_oe_first_q, pad_oe_second_q, rx_valid_q, tx_ready_q;
   iocg_pair_s        pad_in_first, pad_out_first_q, pad_out_second_q;
   logic [WORD_W-1:0] rx_word_q, tx_word;
   int                fails, cmp_count;
   logic [7:0]        cyc;
   iocg_pair_s        log1 [256];
   iocg_pair_s        log2 [256];
   logic [2:0]        rt [5] = '{R2, R4, R8, R10, R7};
   int                nt [5] = '{2, 4, 8, 10, 7};

   iocg_gear uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout_q), .hrdata_q(hrdata_q),
      .hreadyout_q(hreadyout_q), .hresp_q(hresp_q),
      .pad_in_first(pad_in_first), .pad_out_first_q(pad_out_first_q),
      .pad_oe_first_q(pad_oe_first_q), .pad_out_second_q(pad_out_second_q),
      .pad_oe_second_q(pad_oe_second_q), .tristate_ctrl_in(tristate_ctrl_in),
      .rx_word_q(rx_word_q), .rx_valid_q(rx_valid_q), .rx_ready(rx_ready),
      .tx_word(tx_word), .tx_valid(tx_valid), .tx_ready_q(tx_ready_q));

   iocg_far_end fe (.hclk(hclk), .hresetn(hresetn), .run(run),
      .pad_q(pad_in_first));

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end

   // pad history, one entry per clock cycle
   always @(posedge hclk) begin
      cyc <= cyc + 8'h1;
      log1[cyc] <= pad_out_first_q;
      log2[cyc] <= pad_out_second_q;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout_q !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout_q !== 1'b1);
      rd = hrdata_q;
      check("hresp", {31'h0, hresp_q}, 32'h0);
   endtask

   function automatic logic [13:0] mk(logic [2:0] r, logic hp,
                                      logic [2:0] td, logic ti, logic ri);
      iocg_ctrl_s c;
      c = '0;
      c.ratio = r;
      c.bank_hp = hp;
      c.tx_dly = td;
      c.tx_inv = ti;
      c.rx_inv = ri;
      c.diff_en = 1'b1;
      c.filt_byp = 1'b1;
      return c;
   endfunction

   // two words back to back, then the pad pairs are compared in order
   task automatic tx_case(input logic [13:0] ctrl, input int n, input int dly,
                          input logic inv);
      logic [19:0] bits;
      logic [9:0]  w0, w1;
      logic [7:0]  t, ix;
      iocg_pair_s  e;
      w0 = 10'h2B5;
      w1 = 10'h1CA;
      ahb(1'b1, A_CTRL, {18'h0, ctrl}, d);
      repeat (10) @(posedge hclk);
      bits = '0;
      for (int i = 0; i < n; i++) begin
         bits[i] = w0[i];
         bits[n+i] = w1[i];
      end
      tx_word <= w0;
      tx_valid <= 1'b1;
      do @(posedge hclk); while (tx_ready_q !== 1'b1);
      t = cyc;
      tx_word <= w1;
      do @(posedge hclk); while (tx_ready_q !== 1'b1);
      tx_valid <= 1'b0;
      repeat (30) @(posedge hclk);
      for (int k = 0; k < n; k++) begin
         ix = t + 8'(3 + dly + k);
         e = {bits[2*k+1], bits[2*k]} ^ {2{inv}};
         check("tx pair", {30'h0, log1[ix]}, {30'h0, e});
         check("tx second", {30'h0, log2[ix]}, {30'h0, ~e});
      end
      $display("test tx ratio bits %0d done", n);
   endtask

   // each received word must follow its predecessor as table nx says
   task automatic rx_seq(input logic [13:0] ctrl, input logic [7:0] nx);
      logic [9:0] prev;
      int         got;
      ahb(1'b1, A_CTRL, {18'h0, ctrl}, d);
      repeat (60) @(posedge hclk);
      got = 0;
      prev = '0;
      while (got < 9) begin
         @(posedge hclk);
         if (rx_valid_q === 1'b1) begin
            if (got > 0)
               check("rx word", {22'h0, rx_word_q},
                     {30'h0, nx[{prev[1:0], 1'b0} +: 2]});
            prev = rx_word_q;
            got++;
         end
      end
      $display("test rx order %h done", nx);
   endtask

   // filtered counting pattern gives words 1,0,0,3 over and over
   task automatic rx_filt;
      int n2, n3, got;
      ahb(1'b1, A_CTRL, {18'h0, mk(R2, 1'b0, 3'h0, 1'b0, 1'b0) ^ 14'h0080}, d);
      repeat (60) @(posedge hclk);
      n2 = 0;
      n3 = 0;
      got = 0;
      while (got < 8) begin
         @(posedge hclk);
         if (rx_valid_q === 1'b1) begin
            n2 += (rx_word_q == 10'h002);
            n3 += (rx_word_q == 10'h003);
            got++;
         end
      end
      check("filter twos", n2, 32'h0);
      check("filter threes", n3, 32'h2);
      $display("test glitch filter done");
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      #100000;
      fails++;
      report_and_stop();
   end

   initial begin
      hsel = 1'b0;
      haddr = '0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = '0;
      tristate_ctrl_in = 1'b1;
      rx_ready = 1'b1;
      tx_valid = 1'b0;
      tx_word = '0;
      run = 1'b1;
      hresetn = 1'b0;
      fails = 0;
      cmp_count = 0;
      cyc = 8'h0;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, A_CTRL, 32'h0, d);
      check("ctrl reset", d, {18'h0, CTRL_RST});
      ahb(1'b1, A_CTRL, 32'h0000_3FFF, d);
      ahb(1'b0, A_CTRL, 32'h0, d);
      check("ctrl rw", d, 32'h0000_3FFF);
      ahb(1'b1, 8'h20, 32'hFFFF_FFFF, d);
      ahb(1'b0, 8'h20, 32'h0, d);
      check("unmapped", d, 32'h0);
      ahb(1'b0, A_CMD, 32'h0, d);
      check("cmd read", d, 32'h0);
      check("oe hiz", {31'h0, pad_oe_first_q}, 32'h1 ^ 32'h1);
      tristate_ctrl_in <= 1'b0;
      repeat (3) @(posedge hclk);
      check("oe drive", {31'h0, pad_oe_first_q}, 32'h1);
      check("oe second", {31'h0, pad_oe_second_q}, 32'h1);
      $display("test registers done");
      rx_seq(mk(R2, 1'b1, 3'h0, 1'b0, 1'b0), 8'h39);
      rx_seq(mk(R2, 1'b1, 3'h0, 1'b0, 1'b1), 8'h93);
      rx_seq(mk(R4, 1'b0, 3'h0, 1'b0, 1'b0), 8'h39);
      rx_filt();
      ahb(1'b1, A_CMD, 32'h1, d);
      rx_seq(mk(R2, 1'b1, 3'h0, 1'b0, 1'b0), 8'h4B);
      for (int i = 0; i < 5; i++)
         tx_case(mk(rt[i], 1'b1, 3'h0, 1'b0, 1'b0), nt[i], 0, 1'b0);
      tx_case(mk(R4, 1'b0, 3'h0, 1'b0, 1'b0), 2, 0, 1'b0);
      tx_case(mk(R4, 1'b1, 3'h2, 1'b1, 1'b0), 4, 2, 1'b1);
      ahb(1'b1, A_CTRL, {18'h0, mk(R10, 1'b1, 3'h0, 1'b0, 1'b0)}, d);
      rx_ready <= 1'b0;
      repeat (300) @(posedge hclk);
      ahb(1'b0, A_STAT, 32'h0, d);
      check("stat full", d & 32'h7F, 32'h41);
      rx_ready <= 1'b1;
      repeat (100) @(posedge hclk);
      ahb(1'b1, A_STAT, 32'h1, d);
      ahb(1'b0, A_STAT, 32'h0, d);
      check("stat clear", d & 32'h1, 32'h0);
      $display("test fifo done");
      run <= 1'b0;
      repeat (30) @(posedge hclk);
      ahb(1'b1, A_CMD, 32'h2, d);
      ahb(1'b0, A_EDGE, 32'h0, d);
      check("edge clear", d, 32'h0);
      ahb(1'b0, A_STAT, 32'h0, d);
      check("eye flag", d & 32'h80, 32'h0);
      run <= 1'b1;
      repeat (50) @(posedge hclk);
      ahb(1'b0, A_EDGE, 32'h0, d);
      check("edge count", {31'h0, d[15:0] != 0 && d[31:16] != 0}, 32'h1);
      $display("test edge monitor done");
      report_and_stop();
   end
endmodule
`default_nettype wire
